// File: spiob_pkg.sv
// spiob_pkg: register map, field positions and reset values for the spi option/rate/status block
package spiob_pkg;
	// --------------------------------------------------------------
	// register word indices (byte address = 4 * index)
	// --------------------------------------------------------------
	localparam logic [1:0] OPT_IDX = 2'h0;
	localparam logic [1:0] BR_IDX = 2'h1;
	localparam logic [1:0] STAT_IDX = 2'h2;
	localparam logic [1:0] CTL_IDX = 2'h3;
	// --------------------------------------------------------------
	// option_control fields
	// --------------------------------------------------------------
	localparam int OPT_FAULT_EN = 4;
	localparam int OPT_SHARED_OE = 3;
	localparam int OPT_WAIT_STOP = 1;
	localparam int OPT_SINGLE = 0;
	localparam logic [7:0] OPT_MASK = 8'h1b;
	localparam logic [7:0] OPT_RESET = 8'h00;
	// --------------------------------------------------------------
	// bit_rate_select fields
	// --------------------------------------------------------------
	localparam int BR_PRE_LSB = 4;
	localparam int BR_RATE_LSB = 0;
	localparam int BR_FIELD_W = 3;
	localparam logic [7:0] BR_MASK = 8'h77;
	localparam logic [7:0] BR_RESET = 8'h00;
	// --------------------------------------------------------------
	// flag_status and control_main fields
	// --------------------------------------------------------------
	localparam int STAT_READ_FULL = 7;
	localparam int STAT_TX_EMPTY = 5;
	localparam int STAT_MODE_FAULT = 4;
	localparam int CTL_ENABLE = 6;
	localparam int CTL_MASTER = 4;
	localparam int CTL_SELECT_OUTPUT_ENABLE = 1;
	localparam logic [7:0] CTL_MASK = 8'h52;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// --------------------------------------------------------------
	// pin synchroniser slots
	// --------------------------------------------------------------
	localparam int PIN_SS = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_COUNT = 3;
endpackage

// File: spiob_rate_if.sv
// spiob_rate_if: bit-rate settings and tick between the register file and the rate generator
`timescale 1ns/10ps
`default_nettype none
interface spiob_rate_if;
	logic [2:0] prescale;
	logic [2:0] rate;
	logic run;
	logic tick;
	modport gen (input prescale, input rate, input run, output tick);
	modport ctl (output prescale, output rate, output run, input tick);
endinterface // spiob_rate_if
`default_nettype wire

// File: spiob_rate_gen.sv
// spiob_rate_gen: single-stage divide-by-1-to-8 prescaler and power-of-two divider for the master bit clock
`timescale 1ns/10ps
`default_nettype none
module spiob_rate_gen
	import spiob_pkg::*;
#(
	parameter int PRE_W = 3,
	parameter int RATE_W = 3
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// settings and tick
	spiob_rate_if.gen rif
);
	localparam int DIV_W = 1 << RATE_W;

	generate
		if (PRE_W != $bits(rif.prescale) || RATE_W != $bits(rif.rate))
		begin : g_bad_width
			$error("spiob_rate_gen: field widths do not match the interface");
		end
	endgenerate

	logic [PRE_W-1:0] pre_cnt;
	logic [DIV_W-1:0] div_cnt;
	logic tick_q;

	// >= so a lowered setting mid-count wraps at once instead of running the full range
	wire pre_wrap = pre_cnt >= rif.prescale;
	wire [DIV_W-1:0] div_last = DIV_W'((32'd2 << rif.rate) - 32'd1);
	wire div_wrap = pre_wrap && div_cnt >= div_last;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_cnt <= '0;
			div_cnt <= '0;
			tick_q <= 1'b0;
		end
		else if (!rif.run)
		begin
			pre_cnt <= '0;
			div_cnt <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= div_wrap;
			pre_cnt <= pre_wrap ? '0 : pre_cnt + 1'b1;
			if (pre_wrap)
				div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
		end
	end
	assign rif.tick = tick_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	logic [11:0] gap;
	logic seen;
	logic [5:0] cfg_q;
	wire cfg_chg = cfg_q != {rif.prescale, rif.rate};
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gap <= '0;
			seen <= 1'b0;
			cfg_q <= '0;
		end
		else
		begin
			cfg_q <= {rif.prescale, rif.rate};
			gap <= (rif.tick || !rif.run || cfg_chg) ? '0 : gap + 1'b1;
			seen <= rif.run && !cfg_chg && (seen || rif.tick);
		end
	end

	a_tick_period_exact: assert property (@(posedge sys_clk) disable iff (!resetn)
		rif.tick && seen && rif.run && !cfg_chg
		|-> 32'(gap) + 32'd1 == ((32'(rif.prescale) + 32'd1) << (32'(rif.rate) + 32'd1)))
		else $error("bit tick period differs from prescale times divisor");
	a_tick_never_double: assert property (@(posedge sys_clk) disable iff (!resetn)
		rif.tick |=> !rif.tick)
		else $error("bit tick held for two cycles");
	a_halt_stops_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
		!rif.run |=> !rif.tick)
		else $error("bit tick while generator halted");
endmodule // spiob_rate_gen
`default_nettype wire

// File: spiob_top.sv
// spiob_top: spi option, bit-rate and status registers with pin steering and mode-fault detect
`timescale 1ns/10ps
`default_nettype none
module spiob_top
	import spiob_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// avalon-mm slave, word addressed
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// datapath side
	input wire logic tx_bit,
	input wire logic xfer_active,
	input wire logic read_buffer_full,
	input wire logic tx_buffer_empty,
	input wire logic wait_mode,
	output logic rx_bit,
	output logic bit_tick,
	output logic clock_run,
	output logic spi_enable,
	output logic master_select,
	// slave select pin
	input wire logic ss_in,
	output logic ss_out,
	output logic ss_oe,
	output logic ss_port_release,
	// master-output pin
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	output logic mosi_port_release,
	// slave-output pin
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	output logic miso_port_release
);
	logic [7:0] option_control;
	logic [7:0] bit_rate_select;
	logic [7:0] control_main;
	logic mode_fault_flag;
	logic fault_armed;
	logic ack;
	logic [PIN_COUNT-1:0] s1, s2, s3, lvl;

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	wire [PIN_COUNT-1:0] pin_raw = {miso_in, mosi_in, ss_in};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					s1[gi] <= 1'b1;
					s2[gi] <= 1'b1;
					s3[gi] <= 1'b1;
					lvl[gi] <= 1'b1;
				end
				else
				begin
					s1[gi] <= pin_raw[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					// a change only counts once two stages agree
					if (s2[gi] == s3[gi])
						lvl[gi] <= s3[gi];
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	wire req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack;
	wire done = req && ack;
	wire wr_done = done && avs_write;
	wire wr_opt = wr_done && avs_address == OPT_IDX;
	wire wr_br = wr_done && avs_address == BR_IDX;
	wire wr_ctl = wr_done && avs_address == CTL_IDX;
	wire rd_stat = done && avs_read && avs_address == STAT_IDX;

	wire [7:0] stat_rd = {read_buffer_full, 1'b0, tx_buffer_empty, mode_fault_flag, 4'h0};
	wire [7:0] rd_sel =
		(avs_address == OPT_IDX) ? (option_control & OPT_MASK) :
		(avs_address == BR_IDX) ? (bit_rate_select & BR_MASK) :
		(avs_address == STAT_IDX) ? stat_rd :
		(control_main & CTL_MASK);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
		end
		else
		begin
			ack <= req && !ack;
			if (avs_read && !ack)
				avs_readdata <= {24'h0, rd_sel};
		end
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	// a flag_status write lands nowhere: no enable decodes it
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			option_control <= OPT_RESET;
			bit_rate_select <= BR_RESET;
			control_main <= CTL_RESET;
		end
		else
		begin
			if (wr_opt)
				option_control <= avs_writedata[7:0] & OPT_MASK;
			if (wr_br)
				bit_rate_select <= avs_writedata[7:0] & BR_MASK;
			if (wr_ctl)
				control_main <= avs_writedata[7:0] & CTL_MASK;
		end
	end

	wire fault_en = option_control[OPT_FAULT_EN];
	wire shared_oe = option_control[OPT_SHARED_OE];
	wire wait_stop = option_control[OPT_WAIT_STOP];
	wire single = option_control[OPT_SINGLE];
	wire en = control_main[CTL_ENABLE];
	wire master = control_main[CTL_MASTER];
	wire select_output_enable = control_main[CTL_SELECT_OUTPUT_ENABLE];
	assign spi_enable = en;
	assign master_select = master;

	// --------------------------------------------------------------
	// mode fault
	// --------------------------------------------------------------
	wire fault_sense = en && master && fault_en && !select_output_enable;
	wire fault_event = fault_sense && !lvl[PIN_SS];
	// clear needs a status read that saw the flag, then a control write; a new fault wins
	wire next_mode_fault = fault_event || (mode_fault_flag && !(fault_armed && wr_ctl));
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_fault_flag <= 1'b0;
			fault_armed <= 1'b0;
		end
		else
		begin
			mode_fault_flag <= next_mode_fault;
			fault_armed <= wr_ctl ? 1'b0 : (fault_armed || (rd_stat && mode_fault_flag));
		end
	end

	// --------------------------------------------------------------
	// pin steering
	// --------------------------------------------------------------
	wire next_ss_rel = !en || (master && !fault_en);
	wire next_ss_oe = en && master && fault_en && select_output_enable;
	// in single-wire mode the direction bit is the only driver control
	wire next_mosi_oe = en && master && (!single || shared_oe);
	wire next_mosi_rel = !en || (!master && single);
	wire slave_sel = !lvl[PIN_SS];
	wire next_miso_oe = en && !master && (single ? shared_oe : slave_sel);
	wire next_miso_rel = !en || (master && single);
	wire next_rx = (master != single) ? lvl[PIN_MISO] : lvl[PIN_MOSI];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ss_out <= 1'b1;
			ss_oe <= 1'b0;
			ss_port_release <= 1'b1;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			mosi_port_release <= 1'b1;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			miso_port_release <= 1'b1;
			rx_bit <= 1'b0;
		end
		else
		begin
			ss_out <= !xfer_active;
			ss_oe <= next_ss_oe;
			ss_port_release <= next_ss_rel;
			mosi_out <= tx_bit;
			mosi_oe <= next_mosi_oe;
			mosi_port_release <= next_mosi_rel;
			miso_out <= tx_bit;
			miso_oe <= next_miso_oe;
			miso_port_release <= next_miso_rel;
			rx_bit <= next_rx;
		end
	end

	// --------------------------------------------------------------
	// bit-rate generator and wait gating
	// --------------------------------------------------------------
	// halting the divider is the only clock this block owns; the datapath gates on clock_run
	assign clock_run = !(wait_mode && wait_stop);
	spiob_rate_if rif ();
	assign rif.prescale = bit_rate_select[BR_PRE_LSB +: BR_FIELD_W];
	assign rif.rate = bit_rate_select[BR_RATE_LSB +: BR_FIELD_W];
	assign rif.run = en && master && clock_run;
	assign bit_tick = rif.tick;
	spiob_rate_gen #(.PRE_W(BR_FIELD_W), .RATE_W(BR_FIELD_W)) u_rate (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.rif(rif.gen)
	);

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	a_opt_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		avs_read && !ack && avs_address == OPT_IDX |=> avs_readdata[7:5] == 3'h0 && !avs_readdata[2])
		else $error("reserved option bits read non-zero");
	a_stat_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		avs_read && !ack && avs_address == STAT_IDX
		|=> !avs_readdata[6] && avs_readdata[3:0] == 4'h0 && avs_readdata[4] == $past(mode_fault_flag))
		else $error("status read wrong");
	a_slave_select_input: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && !master |=> !ss_oe && !ss_port_release)
		else $error("slave select pin not kept as input in slave mode");
	a_master_ss_release: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && master && !fault_en |-> !fault_event ##1 (ss_port_release && !ss_oe))
		else $error("select pin not released with fault function off");
	a_master_ss_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && master && fault_en |=> !ss_port_release && ss_oe == $past(select_output_enable))
		else $error("select pin direction wrong with fault function on");
	a_fault_sets_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
		fault_sense && !lvl[PIN_SS] |=> mode_fault_flag)
		else $error("mode fault not flagged");
	a_shared_pin_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && single |=> ($past(master) ? mosi_oe : miso_oe) == $past(shared_oe)
		&& ($past(master) ? miso_port_release : mosi_port_release))
		else $error("shared pin driver does not follow direction bit");
	a_dir_bit_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && master && !single |=> mosi_oe && !miso_oe && !mosi_port_release)
		else $error("two-wire master pins wrong");
	a_bitrate_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_br |=> bit_rate_select == ($past(avs_writedata[7:0]) & BR_MASK))
		else $error("bit-rate write lost");
	a_status_write_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_done && avs_address == STAT_IDX && !fault_event && !(fault_armed && wr_ctl)
		|=> mode_fault_flag == $past(mode_fault_flag) && $stable(control_main) && $stable(option_control))
		else $error("status write had an effect");
	a_wait_halts_clock: assert property (@(posedge sys_clk) disable iff (!resetn)
		wait_mode && wait_stop |-> !clock_run ##1 !bit_tick)
		else $error("clocks run in wait mode with wait stop set");
	a_wait_keeps_clock: assert property (@(posedge sys_clk) disable iff (!resetn)
		!wait_stop |-> clock_run)
		else $error("clocks halted with wait stop clear");
	a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
		req && !ack |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus access not answered after one wait cycle");
	a_fault_clear_seq: assert property (@(posedge sys_clk) disable iff (!resetn)
		mode_fault_flag && fault_armed && wr_ctl && !fault_event |=> !mode_fault_flag)
		else $error("mode fault not cleared by armed control write");
	a_fault_needs_sense: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_sense && !mode_fault_flag |=> !mode_fault_flag)
		else $error("mode fault raised without fault sensing");
	a_slave_two_wire: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && !master && !single |=> miso_oe == $past(slave_sel) && !mosi_oe && !miso_port_release)
		else $error("two-wire slave pins wrong");
	a_rx_shared_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
		en && single |=> rx_bit == $past(master ? lvl[PIN_MOSI] : lvl[PIN_MISO]))
		else $error("single-wire receive not taken from the shared pin");
	a_stat_flags_live: assert property (@(posedge sys_clk) disable iff (!resetn)
		avs_read && !ack && avs_address == STAT_IDX
		|=> avs_readdata[7] == $past(read_buffer_full) && avs_readdata[5] == $past(tx_buffer_empty))
		else $error("status flags read wrong");
endmodule // spiob_top
`default_nettype wire

// File: spiob_partner.sv
// spiob_partner: far-side spi device on the select and data pins, with pull-ups
`timescale 1ns/10ps
`default_nettype none
module spiob_partner
(
	// design pin drives
	input wire logic ss_out,
	input wire logic ss_oe,
	input wire logic mosi_out,
	input wire logic mosi_oe,
	input wire logic miso_out,
	input wire logic miso_oe,
	// scenario controls
	input wire logic other_master,
	input wire logic drive_data,
	input wire logic data_bit,
	// resolved pin levels
	output logic ss_in,
	output logic mosi_in,
	output logic miso_in
);
	// a pin nobody drives floats up to the pull-up level
	wire logic peer_mosi = drive_data && !mosi_oe;
	wire logic peer_miso = drive_data && !miso_oe;

	// another master pulls select low only while the design is not driving it
	assign ss_in = ss_oe ? ss_out : !other_master;
	// the peer only drives a data pin that the design has left as input
	assign mosi_in = mosi_oe ? mosi_out : (peer_mosi ? data_bit : 1'b1);
	assign miso_in = miso_oe ? miso_out : (peer_miso ? data_bit : 1'b1);
endmodule // spiob_partner
`default_nettype wire

// File: testbench.sv
// testbench: register, bit-rate, wait and pin steering checks for spiob_top
`timescale 1ns/10ps
`default_nettype none
module testbench
	import spiob_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic tx_bit = 1'b0;
	logic xfer_active = 1'b0;
	logic read_buffer_full = 1'b0;
	logic tx_buffer_empty = 1'b0;
	logic wait_mode = 1'b0;
	logic rx_bit, bit_tick, clock_run, spi_enable, master_select;
	logic ss_in, ss_out, ss_oe, ss_port_release;
	logic mosi_in, mosi_out, mosi_oe, mosi_port_release;
	logic miso_in, miso_out, miso_oe, miso_port_release;
	logic other_master = 1'b0;
	logic drive_data = 1'b0;
	logic data_bit = 1'b0;
	logic [15:0] lfsr = 16'h0010;
	logic [31:0] exp_q [$];
	int miscompares = 0;
	int samples_checked = 0;
	int ticks;
	logic [7:0] br_tab [6] = '{8'h00, 8'h07, 8'h70, 8'h73, 8'h26, 8'h77};
	logic [7:0] ss_ctl [4] = '{8'h40, 8'h50, 8'h52, 8'h50};
	logic [7:0] ss_opt [4] = '{8'h10, 8'h00, 8'h10, 8'h10};
	logic [1:0] ss_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	logic [7:0] pc_ctl [6] = '{8'h50, 8'h50, 8'h50, 8'h40, 8'h40, 8'h40};
	logic [7:0] pc_opt [6] = '{8'h08, 8'h01, 8'h09, 8'h01, 8'h09, 8'h08};
	logic [3:0] pc_exp [6] = '{4'h8, 4'h1, 4'h9, 4'h2, 4'h6, 4'h0};
	logic pc_rx_mosi [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	always #50 sys_clk = ~sys_clk;

	spiob_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_bit(tx_bit), .xfer_active(xfer_active),
		.read_buffer_full(read_buffer_full), .tx_buffer_empty(tx_buffer_empty), .wait_mode(wait_mode),
		.rx_bit(rx_bit), .bit_tick(bit_tick), .clock_run(clock_run), .spi_enable(spi_enable),
		.master_select(master_select), .ss_in(ss_in), .ss_out(ss_out), .ss_oe(ss_oe),
		.ss_port_release(ss_port_release), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.mosi_port_release(mosi_port_release), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
		.miso_port_release(miso_port_release));

	spiob_partner i_partner (.ss_out(ss_out), .ss_oe(ss_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.miso_out(miso_out), .miso_oe(miso_oe), .other_master(other_master), .drive_data(drive_data),
		.data_bit(data_bit), .ss_in(ss_in), .mosi_in(mosi_in), .miso_in(miso_in));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// waitrequest is sampled at the rising edge; the request drops only after the edge that sees it low
	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic bus_rd(input logic [1:0] a, input logic [7:0] d);
		exp_q.push_back({24'h000000, d});
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic settle();
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic count_ticks();
		ticks = 0;
		repeat (20)
		begin
			@(posedge sys_clk);
			ticks += int'(bit_tick === 1'b1);
		end
	endtask

	// measures the gap between two ticks; the first gap may still carry the old setting
	task automatic tick_period(input logic [7:0] br);
		int n;
		int want;
		want = (br[6:4] + 1) * (2 << br[2:0]);
		bus_wr(BR_IDX, br);
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(posedge sys_clk);
				n++;
			end while (bit_tick !== 1'b1 && n < 5000);
		end
		check(n, want);
	endtask

	// read data are judged at the edge that completes the read
	always @(posedge sys_clk)
		if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
			check(avs_readdata, exp_q.pop_front());

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		bus_rd(OPT_IDX, 8'h00);
		bus_rd(BR_IDX, 8'h00);
		bus_rd(STAT_IDX, 8'h00);
		bus_wr(OPT_IDX, 8'hff);
		bus_rd(OPT_IDX, 8'h1b);
		read_buffer_full <= 1'b1;
		tx_buffer_empty <= 1'b1;
		bus_wr(STAT_IDX, 8'h5f);
		bus_rd(STAT_IDX, 8'ha0);
		for (int i = 0; i < 6; i++)
		begin
			lfsr = lfsr_next(lfsr);
			bus_wr(BR_IDX, lfsr[7:0]);
			bus_rd(BR_IDX, lfsr[7:0] & BR_MASK);
		end
		$display("done: register access");
		bus_wr(OPT_IDX, 8'h00);
		bus_wr(CTL_IDX, 8'h50);
		foreach (br_tab[i])
			tick_period(br_tab[i]);
		lfsr = lfsr_next(lfsr);
		tick_period(lfsr[7:0] & BR_MASK);
		$display("done: bit rate");
		bus_wr(BR_IDX, 8'h00);
		wait_mode <= 1'b1;
		bus_wr(OPT_IDX, 8'h02);
		settle();
		check(clock_run, 1'b0);
		count_ticks();
		check(ticks, 0);
		bus_wr(OPT_IDX, 8'h00);
		settle();
		check(clock_run, 1'b1);
		count_ticks();
		check(ticks, 10);
		wait_mode <= 1'b0;
		$display("done: wait stop");
		for (int i = 0; i < 4; i++)
		begin
			bus_wr(CTL_IDX, ss_ctl[i]);
			bus_wr(OPT_IDX, ss_opt[i]);
			settle();
			check({ss_oe, ss_port_release}, ss_exp[i]);
		end
		bus_wr(CTL_IDX, 8'h52);
		xfer_active <= 1'b1;
		settle();
		check({ss_oe, ss_out}, 2'h2);
		xfer_active <= 1'b0;
		other_master <= 1'b1;
		bus_wr(CTL_IDX, 8'h40);
		settle();
		bus_rd(STAT_IDX, 8'ha0);
		bus_wr(OPT_IDX, 8'h00);
		bus_wr(CTL_IDX, 8'h50);
		settle();
		bus_rd(STAT_IDX, 8'ha0);
		bus_wr(OPT_IDX, 8'h10);
		settle();
		bus_rd(STAT_IDX, 8'hb0);
		other_master <= 1'b0;
		settle();
		bus_wr(CTL_IDX, 8'h50);
		bus_rd(STAT_IDX, 8'ha0);
		$display("done: select pin");
		drive_data <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			lfsr = lfsr_next(lfsr);
			tx_bit <= lfsr[0];
			data_bit <= lfsr[1];
			bus_wr(CTL_IDX, pc_ctl[i]);
			bus_wr(OPT_IDX, pc_opt[i]);
			settle();
			check({mosi_oe, miso_oe, mosi_port_release, miso_port_release}, pc_exp[i]);
			check(mosi_out, lfsr[0]);
			check(miso_out, lfsr[0]);
			check({spi_enable, master_select}, {pc_ctl[i][CTL_ENABLE], pc_ctl[i][CTL_MASTER]});
			check(rx_bit, pc_rx_mosi[i] ? mosi_in : miso_in);
		end
		$display("done: data pins");
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		bus_rd(OPT_IDX, 8'h00);
		bus_rd(BR_IDX, 8'h00);
		$display("done: reset in mid-run");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
